// File: srtb_pkg.sv
// Purpose: Constants and functions for the serial receive timeout buffer.
// Assumes: 50 MHz reference clock.
// Notes:   Register offsets are byte addresses on a 32-bit Avalon-MM slave.
`default_nettype none
package srtb_pkg;
   // Clock rate and buffer size
   localparam int unsigned CLK_HZ        = 50000000;
   localparam int unsigned BUF_DEPTH     = 48;
   // Timer tick: 20 ms resolution of the gap timer
   localparam int unsigned TICK_MS       = 20;
   localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
   // Gap timeouts in milliseconds, per baud code
   localparam int unsigned TMO_1200_MS   = 160;
   localparam int unsigned TMO_2400_MS   = 80;
   localparam int unsigned TMO_4800_MS   = 40;
   localparam int unsigned TMO_9600_MS   = 20;
   localparam int unsigned TMO_19200_MS  = 20;
   // Baud codes
   localparam logic [2:0]  BAUD_1200     = 3'h2;
   localparam logic [2:0]  BAUD_2400     = 3'h3;
   localparam logic [2:0]  BAUD_4800     = 3'h4;
   localparam logic [2:0]  BAUD_9600     = 3'h5;
   localparam logic [2:0]  BAUD_19200    = 3'h6;
   // Parity codes
   localparam logic [1:0]  PAR_NONE      = 2'h0;
   localparam logic [1:0]  PAR_ODD       = 2'h1;
   localparam logic [1:0]  PAR_EVEN      = 2'h2;
   // Stop codes: one, one and a half, two bit times
   localparam logic [1:0]  STOP_1        = 2'h0;
   localparam logic [1:0]  STOP_15       = 2'h1;
   localparam logic [1:0]  STOP_2        = 2'h2;
   // Register byte offsets
   localparam logic [5:0]  OFS_BAUD      = 6'h00;
   localparam logic [5:0]  OFS_DBITS     = 6'h04;
   localparam logic [5:0]  OFS_PARITY    = 6'h08;
   localparam logic [5:0]  OFS_STOP      = 6'h0c;
   localparam logic [5:0]  OFS_COUNT     = 6'h10;
   localparam logic [5:0]  OFS_STATUS    = 6'h14;
   localparam logic [5:0]  OFS_DATA      = 6'h18;
   // Status field positions
   localparam int unsigned ST_PERR_BIT   = 0;
   localparam int unsigned ST_ACT_BIT    = 1;
   // Reset values
   localparam logic [2:0]  RST_BAUD      = BAUD_9600;
   localparam logic [3:0]  RST_DBITS     = 4'h8;
   localparam logic [1:0]  RST_PARITY    = PAR_NONE;
   localparam logic [1:0]  RST_STOP      = STOP_1;
   // Oversample period (1/16 bit) in ref_clk cycles for a baud code
   function automatic logic [11:0] srtb_os_div(input logic [2:0] code);
      case (code)
         BAUD_1200:  srtb_os_div = 12'(CLK_HZ / (1200 * 16));
         BAUD_2400:  srtb_os_div = 12'(CLK_HZ / (2400 * 16));
         BAUD_4800:  srtb_os_div = 12'(CLK_HZ / (4800 * 16));
         BAUD_19200: srtb_os_div = 12'(CLK_HZ / (19200 * 16));
         default:    srtb_os_div = 12'(CLK_HZ / (9600 * 16));
      endcase
   endfunction
   // Gap timeout in 20 ms ticks for a baud code
   function automatic logic [3:0] srtb_tmo_ticks(input logic [2:0] code);
      case (code)
         BAUD_1200:  srtb_tmo_ticks = 4'(TMO_1200_MS / TICK_MS);
         BAUD_2400:  srtb_tmo_ticks = 4'(TMO_2400_MS / TICK_MS);
         BAUD_4800:  srtb_tmo_ticks = 4'(TMO_4800_MS / TICK_MS);
         BAUD_19200: srtb_tmo_ticks = 4'(TMO_19200_MS / TICK_MS);
         default:    srtb_tmo_ticks = 4'(TMO_9600_MS / TICK_MS);
      endcase
   endfunction
endpackage
`default_nettype wire

// File: srtb_char_if.sv
// Purpose: Carries received characters from the line receiver.
// Assumes: One clock domain.
// Notes:   charValid is a one-cycle pulse.
`default_nettype none
interface srtb_char_if;
   logic [7:0] charData;   // Received data, 7-bit mode zero-filled
   logic       charValid;  // One-cycle pulse per character
   logic       charPerr;   // Parity mismatch on this character
   modport src (output charData, output charValid, output charPerr);
   modport dst (input charData, input charValid, input charPerr);
endinterface
`default_nettype wire

// File: srtb_line_rx.sv
// Purpose: Asynchronous serial character receiver, 16x oversampled.
// Assumes: rxLine is already synchronous to ref_clk.
// Notes:   Stop interval is not sampled; the character is delivered at its first mid point.
`default_nettype none
module srtb_line_rx
   import srtb_pkg::*;
(
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   // Configuration
   input  wire logic [2:0] baudCode,
   input  wire logic [3:0] dataBits,
   input  wire logic [1:0] parityMode,
   // Serial line
   input  wire logic       rxLine,
   // Characters out
   srtb_char_if.src        chr
);
   typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} srtb_rx_e;
   srtb_rx_e    state;                   // Receiver state
   logic [11:0] osCnt;                   // Oversample divider
   logic [3:0]  phase;                   // 16 oversamples per bit
   logic [3:0]  bitIdx;                  // Data bit index
   logic [7:0]  shiftReg;                // Assembled data
   logic        parAcc;                  // Running xor of data
   wire         osTick  = (osCnt == 12'h000);
   wire         midBit  = osTick && (phase == 4'h7);
   wire         endBit  = osTick && (phase == 4'hf);
   wire         lastBit = (bitIdx == dataBits - 4'h1);
   wire         usePar  = (parityMode != PAR_NONE);
   // Odd parity wants total ones odd, even wants them even
   wire         parBad  = (parAcc ^ rxLine) != (parityMode == PAR_ODD);

   // Oversample divider: one enable pulse per 1/16 bit
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) osCnt <= 12'h000;
      else if (state == S_IDLE || osTick) osCnt <= srtb_os_div(baudCode) - 12'h001;
      else osCnt <= osCnt - 12'h001;
   end

   // Frame state machine
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= S_IDLE;
         phase <= 4'h0;
         bitIdx <= 4'h0;
         shiftReg <= 8'h00;
         parAcc <= 1'b0;
         chr.charValid <= 1'b0;
         chr.charData <= 8'h00;
         chr.charPerr <= 1'b0;
      end else begin
         chr.charValid <= 1'b0;
         if (osTick && state != S_IDLE) phase <= phase + 4'h1;
         unique case (state)
            S_IDLE: begin
               phase <= 4'h0;
               if (!rxLine) state <= S_START;
            end
            S_START: begin
               // False start when line is high again at mid bit
               if (midBit) state <= rxLine ? S_IDLE : S_START;
               if (endBit) begin
                  state <= S_DATA;
                  bitIdx <= 4'h0;
                  parAcc <= 1'b0;
                  shiftReg <= 8'h00;
               end
            end
            S_DATA: begin
               if (midBit) begin
                  // LSB first; bit lands at its index for 7 or 8 bits
                  shiftReg[bitIdx[2:0]] <= rxLine;
                  parAcc <= parAcc ^ rxLine;
               end
               if (endBit) begin
                  bitIdx <= bitIdx + 4'h1;
                  if (lastBit) state <= usePar ? S_PAR : S_STOP;
               end
            end
            S_PAR: begin
               if (midBit) chr.charPerr <= parBad;
               if (endBit) state <= S_STOP;
            end
            S_STOP: begin
               // Deliver at stop mid point; 1.5 or 2 stop bits just idle longer
               if (midBit) begin
                  chr.charData <= shiftReg;
                  chr.charValid <= 1'b1;
                  if (!usePar) chr.charPerr <= 1'b0;
                  state <= S_IDLE;
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// File: srtb_top.sv
// Purpose: Receive side of a serial port with a 48-byte gap-timed buffer.
// Assumes: 50 MHz ref_clk; Avalon-MM slave with waitrequest.
// Notes:   Reads and writes are answered one cycle after the request rises.
//
// Design decisions made here: the Avalon-MM slave port and the register addresses.
`default_nettype none

module srtb_top
   import srtb_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // Avalon-MM slave
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output var  logic [31:0] avs_readdata,
   output var  logic        avs_waitrequest,
   // Serial line
   input  wire logic        rxLine,
   // Status pins
   output var  logic [5:0]  rxCount,
   output var  logic        rxParityErr
);
   srtb_char_if chr ();                  // Receiver to buffer

   logic [2:0]  baudCode;                // Line rate code
   logic [3:0]  dataBits;                // 7 or 8
   logic [1:0]  parityMode;              // Parity setting
   logic [1:0]  stopMode;                // Stop interval setting
   logic [7:0]  bufMem [BUF_DEPTH];      // Receive buffer storage
   logic [5:0]  bufCount;                // Bytes held
   logic        blockPerr;               // Parity error in current block
   logic [5:0]  readIdx;                 // Data port read index
   logic [24:0] tickCnt;                 // 20 ms timebase divider
   logic [3:0]  gapTicks;                // Elapsed gap ticks
   logic        gapRun;                  // Gap timer running
   logic        rdPend;                  // Bus answer cycle, read or write

   // Decoding
   wire         tick20    = (tickCnt == 25'(TICK_CYCLES - 1));
   wire         gapExpire = gapRun && tick20 && (gapTicks + 4'h1 >= srtb_tmo_ticks(baudCode));
   wire         freshStart = !gapRun || (bufCount == 6'(BUF_DEPTH));
   // Write lands only at the edge where the master sees waitrequest low
   wire         wrStrobe  = avs_write && !avs_waitrequest && avs_byteenable[0];
   wire         selBaud   = wrStrobe && (avs_address == OFS_BAUD);
   wire         selDbits  = wrStrobe && (avs_address == OFS_DBITS);
   wire         selParity = wrStrobe && (avs_address == OFS_PARITY);
   wire         selStop   = wrStrobe && (avs_address == OFS_STOP);
   wire         rdData    = avs_read && !rdPend && (avs_address == OFS_DATA);
   // First cycle of any transfer; the answer follows one cycle later
   wire         busStart  = (avs_read || avs_write) && !rdPend;
   wire [2:0]   wBaud     = avs_writedata[2:0];
   wire [3:0]   wDbits    = avs_writedata[3:0];
   wire         baudOk    = (wBaud >= BAUD_1200) && (wBaud <= BAUD_19200);
   wire         dbitsOk   = (wDbits == 4'h7) || (wDbits == 4'h8);
   wire [31:0]  next_readdata =
      (avs_address == OFS_BAUD)   ? {29'h0, baudCode}   :
      (avs_address == OFS_DBITS)  ? {28'h0, dataBits}   :
      (avs_address == OFS_PARITY) ? {30'h0, parityMode} :
      (avs_address == OFS_STOP)   ? {30'h0, stopMode}   :
      (avs_address == OFS_COUNT)  ? {26'h0, bufCount}   :
      (avs_address == OFS_STATUS) ? {30'h0, gapRun, blockPerr} :
      (avs_address == OFS_DATA)   ? {24'h0, bufMem[readIdx]} :
      32'h0;

   // Line receiver
   srtb_line_rx u_rx (
      .ref_clk    (ref_clk),
      .rst_n      (rst_n),
      .baudCode   (baudCode),
      .dataBits   (dataBits),
      .parityMode (parityMode),
      .rxLine     (rxLine),
      .chr        (chr)
   );

   // Configuration registers, invalid codes ignored
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         baudCode   <= RST_BAUD;
         dataBits   <= RST_DBITS;
         parityMode <= RST_PARITY;
         stopMode   <= RST_STOP;
      end else begin
         if (selBaud && baudOk) baudCode <= wBaud;
         if (selDbits && dbitsOk) dataBits <= wDbits;
         if (selParity && avs_writedata[1:0] != 2'h3) parityMode <= avs_writedata[1:0];
         if (selStop && avs_writedata[1:0] != 2'h3) stopMode <= avs_writedata[1:0];
      end
   end

   // 20 ms timebase, realigned on each character
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) tickCnt <= 25'h0;
      else if (chr.charValid || tick20) tickCnt <= 25'h0;
      else tickCnt <= tickCnt + 25'h1;
   end

   // Gap timer: restart per character, stop on expiry
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         gapRun <= 1'b0;
         gapTicks <= 4'h0;
      end else if (chr.charValid) begin
         gapRun <= 1'b1;
         gapTicks <= 4'h0;
      end else if (gapExpire) begin
         gapRun <= 1'b0;
      end else if (gapRun && tick20) begin
         gapTicks <= gapTicks + 4'h1;
      end
   end

   // Buffer fill: append, or restart after timeout or when full
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bufCount <= 6'h00;
         blockPerr <= 1'b0;
      end else if (chr.charValid) begin
         if (freshStart) begin
            bufCount <= 6'h01;
            blockPerr <= chr.charPerr;
         end else begin
            bufCount <= bufCount + 6'h01;
            blockPerr <= blockPerr | chr.charPerr;
         end
      end
   end

   // Buffer storage, indexed by position
   always_ff @(posedge ref_clk) begin
      if (chr.charValid) bufMem[freshStart ? 6'h00 : bufCount] <= chr.charData;
   end

   // Data port read index: rewinds on new stream, steps per data read
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) readIdx <= 6'h00;
      else if (chr.charValid && freshStart) readIdx <= 6'h00;
      else if (rdData && readIdx < 6'(BUF_DEPTH - 1)) readIdx <= readIdx + 6'h01;
   end

   // Bus answer: reads and writes both answered one cycle after they rise
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdPend <= 1'b0;
         avs_readdata <= 32'h0;
         avs_waitrequest <= 1'b1;
      end else begin
         rdPend <= busStart;
         avs_readdata <= next_readdata;
         avs_waitrequest <= !busStart;
      end
   end

   // Status pins mirror the buffer state
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rxCount <= 6'h00;
         rxParityErr <= 1'b0;
      end else begin
         rxCount <= bufCount;
         rxParityErr <= blockPerr;
      end
   end
endmodule
`default_nettype wire

// File: srtb_top_props.sv
// Purpose: Port assertions for the serial receive buffer.
// Assumes: One clock domain, async active-low reset.
// Notes:   Attached to srtb_top by bind.
`default_nettype none
module srtb_top_props
   import srtb_pkg::*;
(
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   // Bus handshake
   input  wire logic       avs_read,
   input  wire logic       avs_write,
   input  wire logic       avs_waitrequest,
   // Receive status
   input  wire logic [5:0] rxCount,
   input  wire logic       rxParityErr
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Count never exceeds the buffer depth
   property p_cnt_max; rxCount <= 6'h30; endproperty
   a_cnt_max: assert property (p_cnt_max) else $error("count above buffer depth");
   // Count only steps up by one or restarts at one
   property p_cnt_step;
      $changed(rxCount) |-> (rxCount == $past(rxCount) + 6'h01) || (rxCount == 6'h01);
   endproperty
   a_cnt_step: assert property (p_cnt_step) else $error("count moved oddly");
   // A full buffer restarts with the new byte
   property p_full; ($past(rxCount) == 6'h30) && $changed(rxCount) |-> rxCount == 6'h01; endproperty
   a_full: assert property (p_full) else $error("full buffer not restarted");
   // One character cannot be counted twice in a row
   property p_one_char; $changed(rxCount) |=> $stable(rxCount) [*8]; endproperty
   a_one_char: assert property (p_one_char) else $error("count moved twice");
   // A read is answered one cycle after it rises
   property p_rd_wait; $rose(avs_read) |=> !avs_waitrequest; endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read answer late");
   // The read answer stands for one cycle
   property p_wait_one; avs_read && !avs_waitrequest |=> avs_waitrequest; endproperty
   a_wait_one: assert property (p_wait_one) else $error("read answer too long");
   // A write is answered one cycle after it rises
   property p_wr_wait; $rose(avs_write) |=> !avs_waitrequest; endproperty
   a_wr_wait: assert property (p_wr_wait) else $error("write answer late");
   // Parity flag rises only with a received character
   property p_perr_rise; $rose(rxParityErr) |-> rxCount != $past(rxCount, 2); endproperty
   a_perr_rise: assert property (p_perr_rise) else $error("flag without character");
   // Parity flag clears only when a new stream starts
   property p_perr_fell; $fell(rxParityErr) |-> ##[0:2] (rxCount == 6'h01); endproperty
   a_perr_fell: assert property (p_perr_fell) else $error("flag cleared mid block");
endmodule
bind srtb_top srtb_top_props u_props (.ref_clk(ref_clk), .rst_n(rst_n), .avs_read(avs_read),
   .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .rxCount(rxCount),
   .rxParityErr(rxParityErr));
`default_nettype wire

// File: srtb_far_tx.sv
// Purpose: Remote serial equipment that sends characters to the receiver.
// Assumes: Bit time given in ref_clk cycles by the caller.
// Notes:   Line rests at the mark level between characters.
`default_nettype none
module srtb_far_tx
   import srtb_pkg::*;
(
   // Clock
   input  wire logic ref_clk,
   // Serial line toward the receiver
   output var  logic txLine
);
   timeunit 1ns;
   timeprecision 1ps;
   initial txLine = 1'b1; // Idle mark level
   // Start bit, data LSB first, optional parity, stop time in half bits
   task automatic send_char(input logic [7:0] d, input int nBits, input logic [1:0] par,
                            input logic badPar, input int stopHalves, input int bitCyc);
      logic p;
      p = (^(d & 8'((1 << nBits) - 1))) ^ (par == PAR_ODD) ^ badPar;
      @(posedge ref_clk);
      txLine <= 1'b0;
      repeat (bitCyc) @(posedge ref_clk);
      for (int i = 0; i < nBits; i++) begin
         txLine <= d[i];
         repeat (bitCyc) @(posedge ref_clk);
      end
      if (par != PAR_NONE) begin
         txLine <= p;
         repeat (bitCyc) @(posedge ref_clk);
      end
      txLine <= 1'b1;
      repeat (stopHalves * bitCyc / 2) @(posedge ref_clk);
   endtask
endmodule
`default_nettype wire

// File: tb_serial_rx_timeout_buffer.sv
// Purpose: Self-checking bench for the serial receive buffer.
// Assumes: 19200 baud keeps each character near 29k cycles.
// Notes:   The 20 ms gap timer never expires within this run.
`default_nettype none
module tb_serial_rx_timeout_buffer
   import srtb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BIT_CYC = CLK_HZ / 19200; // Bit time at 19200 baud
   logic        ref_clk, rst_n, avs_read, avs_write, rxLine, rxParityErr, avs_waitrequest;
   logic [5:0]  avs_address, rxCount;
   logic [31:0] avs_writedata, avs_readdata, rdData;
   logic [3:0]  avs_byteenable;
   int          mismatches, checks_done;
   srtb_far_tx far (.ref_clk(ref_clk), .txLine(rxLine));
   srtb_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .rxLine(rxLine), .rxCount(rxCount),
      .rxParityErr(rxParityErr));
   always #10 ref_clk = ~ref_clk;
   // Compare one value and count it
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // One bus transfer, held until waitrequest is sampled low
   task automatic bus_xfer(input logic [5:0] a, input logic wr, input logic [31:0] wd);
      int n;
      @(posedge ref_clk);
      avs_address <= a;
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= wd;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      rdData = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 20) chk(32'h1, 32'h0, "bus answer missing");
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus_xfer(a, 1'b1, d);
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] exp);
      bus_xfer(a, 1'b0, 32'h0);
      chk(rdData, exp, "register read");
   endtask
   // Settings after reset, and an unmapped place
   task automatic t_defaults();
      rd(OFS_BAUD, 32'(RST_BAUD));
      rd(OFS_DBITS, 32'h8);
      rd(OFS_PARITY, 32'(PAR_NONE));
      rd(OFS_STOP, 32'(STOP_1));
      rd(OFS_COUNT, 32'h0);
      rd(6'h1c, 32'h0);
      $display("defaults test done");
   endtask
   // Every setting written and read back, illegal baud and data-bit values ignored
   task automatic t_config();
      for (int c = 2; c <= 6; c++) begin
         wr(OFS_BAUD, 32'(c));
         rd(OFS_BAUD, 32'(c));
      end
      wr(OFS_BAUD, 32'h7);
      rd(OFS_BAUD, 32'(BAUD_19200));
      for (int c = 0; c <= 2; c++) begin
         wr(OFS_PARITY, 32'(c));
         rd(OFS_PARITY, 32'(c));
         wr(OFS_STOP, 32'(c));
         rd(OFS_STOP, 32'(c));
      end
      wr(OFS_DBITS, 32'h7);
      wr(OFS_DBITS, 32'h9);
      rd(OFS_DBITS, 32'h7);
      wr(OFS_DBITS, 32'h8);
      $display("config test done");
   endtask
   // Close characters append; a bad parity bit flags the block
   task automatic t_stream();
      far.send_char(8'ha5, 8, PAR_EVEN, 1'b0, 2, BIT_CYC);
      chk({26'h0, rxCount}, 32'h1, "first count");
      rd(OFS_STATUS, 32'h2);
      wr(OFS_PARITY, 32'(PAR_ODD));
      far.send_char(8'h3c, 8, PAR_ODD, 1'b0, 4, BIT_CYC);
      rd(OFS_STATUS, 32'h2);
      rd(OFS_COUNT, 32'h2);
      rd(OFS_DATA, 32'ha5);
      rd(OFS_DATA, 32'h3c);
      wr(OFS_DBITS, 32'h7);
      far.send_char(8'hd3, 7, PAR_ODD, 1'b1, 3, BIT_CYC);
      rd(OFS_COUNT, 32'h3);
      rd(OFS_DATA, 32'h53);
      rd(OFS_STATUS, 32'h3);
      chk({31'h0, rxParityErr}, 32'h1, "parity pin");
      $display("stream test done");
   endtask
   // Counts, verdict and end of run
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      ref_clk = 1'b0;
      rst_n = 1'b0;
      avs_address = 6'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
      mismatches = 0;
      checks_done = 0;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_defaults();
      t_config();
      t_stream();
      give_verdict();
   end
   // Watchdog about a tenth beyond the three characters
   initial begin
      repeat (96000) @(posedge ref_clk);
      mismatches++;
      give_verdict();
   end
endmodule
`default_nettype wire
